// *** src/gpb_params.svh ***
// constants for the general io port bank
`ifndef GPB_PARAMS_SVH
`define GPB_PARAMS_SVH
`define GPB_NPORT      3
`define GPB_PX0        0
`define GPB_PX2        1
`define GPB_PX4        2
`define GPB_ZERO8      8'h00
`define GPB_ONES8      8'hFF
// port 0 masks per package
`define GPB_P0_IMPL_8  8'h1A
`define GPB_P0_IMPL_10 8'h1F
`define GPB_P0_IMPL_16 8'hFF
`define GPB_P0_OD_8    8'h0A
`define GPB_P0_OD_10   8'h0B
`define GPB_P0_OD_16   8'hFB
`define GPB_P0_ANA_8   8'h1A
`define GPB_P0_ANA_10  8'h1E
`define GPB_P0_ANA_16  8'hFE
// port 2 exists only in the largest package
`define GPB_P2_IMPL_20 8'h0F
`define GPB_P2_OD_20   8'h04
`define GPB_P2_ANA_20  8'h0F
// port 4 masks per package
`define GPB_P4_IMPL_8  8'h01
`define GPB_P4_IMPL_16 8'h03
`define GPB_P4_OD_20   8'h02
// package pin counts
`define GPB_PINS_8     8
`define GPB_PINS_10    10
`define GPB_PINS_16    16
`define GPB_PINS_20    20
`endif

// *** src/gpb_pkg.sv ***
// types for the general io port bank
package gpb_pkg;
  // which mask a lookup returns
  typedef enum logic [2:0] {
    GPB_K_IMPL = 3'b001,
    GPB_K_OD   = 3'b010,
    GPB_K_ANA  = 3'b100
  } gpb_kind_t;

  // software write strobes for one port
  typedef struct packed {
    logic data;
    logic direction;
    logic pullup_select;
    logic output_type;
    logic analog_digital_select;
  } gpb_wr_t;

  // software visible registers of one port
  typedef struct packed {
    logic [7:0] data;
    logic [7:0] direction;
    logic [7:0] pullup_select;
    logic [7:0] output_type;
    logic [7:0] analog_digital_select;
  } gpb_cfg_t;

  typedef logic [2:0][7:0] gpb_vec_t;

  // whole state of the bank
  typedef struct packed {
    gpb_cfg_t [2:0] cfg;
    gpb_vec_t       sync1;
    gpb_vec_t       sync2;
    gpb_vec_t       sync3;
    gpb_vec_t       level;
    gpb_vec_t       pin_out;
    gpb_vec_t       pin_oe;
    gpb_vec_t       pullup_en;
    gpb_vec_t       analog_en;
    gpb_vec_t       rdata;
  } gpb_state_t;
endpackage : gpb_pkg

// *** src/gpb_port_bank.sv ***
// general io port bank: ports 0, 2 and 4 with latches and pin control
`include "gpb_params.svh"

module gpb_port_bank
  import gpb_pkg::*;
#(
  parameter int PINS = `GPB_PINS_20
) (
  // clock and reset
  input  wire logic                REF_CLK,
  input  wire logic                RST,
  // software writes, index 0/1/2 = port 0/2/4
  input  wire gpb_wr_t [2:0]       WR,
  input  wire logic [7:0]          WR_DATA,
  // pins
  input  wire gpb_vec_t            PIN_IN,
  output gpb_vec_t                 PIN_OUT,
  output gpb_vec_t                 PIN_OE,
  output gpb_vec_t                 PULLUP_EN,
  output gpb_vec_t                 ANALOG_EN,
  // software reads
  output gpb_vec_t                 RDATA,
  output gpb_cfg_t [2:0]           CFG
);

  // port 0 masks: implemented, open-drain capable, analog capable
  function automatic logic [7:0] port0_mask(
    input int        pins,
    input gpb_kind_t kind
  );
    logic [7:0] m;
    m = `GPB_ZERO8;
    case (kind)
      GPB_K_IMPL: begin
        case (pins)
          `GPB_PINS_8:  m = `GPB_P0_IMPL_8;
          `GPB_PINS_10: m = `GPB_P0_IMPL_10;
          default:      m = `GPB_P0_IMPL_16;
        endcase
      end
      GPB_K_OD: begin
        case (pins)
          `GPB_PINS_8:  m = `GPB_P0_OD_8;
          `GPB_PINS_10: m = `GPB_P0_OD_10;
          default:      m = `GPB_P0_OD_16;
        endcase
      end
      GPB_K_ANA: begin
        case (pins)
          `GPB_PINS_8:  m = `GPB_P0_ANA_8;
          `GPB_PINS_10: m = `GPB_P0_ANA_10;
          default:      m = `GPB_P0_ANA_16;
        endcase
      end
      default: begin
        m = `GPB_ZERO8;
      end
    endcase
    return m;
  endfunction : port0_mask

  // port 2 masks: these bits bond out in the largest package only
  function automatic logic [7:0] port2_mask(
    input int        pins,
    input gpb_kind_t kind
  );
    logic [7:0] m;
    m = `GPB_ZERO8;
    if (pins == `GPB_PINS_20) begin
      case (kind)
        GPB_K_IMPL: begin
          m = `GPB_P2_IMPL_20;
        end
        GPB_K_OD: begin
          m = `GPB_P2_OD_20;
        end
        GPB_K_ANA: begin
          m = `GPB_P2_ANA_20;
        end
        default: begin
          m = `GPB_ZERO8;
        end
      endcase
    end
    return m;
  endfunction : port2_mask

  // port 4 masks: no analog path on this port
  function automatic logic [7:0] port4_mask(
    input int        pins,
    input gpb_kind_t kind
  );
    logic [7:0] m;
    m = `GPB_ZERO8;
    case (kind)
      GPB_K_IMPL: begin
        case (pins)
          `GPB_PINS_8:  m = `GPB_P4_IMPL_8;
          `GPB_PINS_10: m = `GPB_P4_IMPL_8;
          default:      m = `GPB_P4_IMPL_16;
        endcase
      end
      GPB_K_OD: begin
        case (pins)
          `GPB_PINS_20: m = `GPB_P4_OD_20;
          default:      m = `GPB_ZERO8;
        endcase
      end
      default: begin
        m = `GPB_ZERO8;
      end
    endcase
    return m;
  endfunction : port4_mask

  // mask lookup by package, port and kind
  function automatic logic [7:0] mask_of(
    input int        pins,
    input int        port,
    input gpb_kind_t kind
  );
    logic [7:0] m;
    m = `GPB_ZERO8;
    case (port)
      `GPB_PX0: m = port0_mask(pins, kind);
      `GPB_PX2: m = port2_mask(pins, kind);
      `GPB_PX4: m = port4_mask(pins, kind);
      default:  m = `GPB_ZERO8;
    endcase
    return m;
  endfunction : mask_of

  // masked write keeps unimplemented bits at their reset value
  function automatic logic [7:0] merge(
    input logic [7:0] old_v,
    input logic [7:0] new_v,
    input logic [7:0] m
  );
    return (new_v & m) | (old_v & ~m);
  endfunction : merge

  // two agreeing late stages move the level; otherwise it holds
  function automatic logic [7:0] settle(
    input logic [7:0] s2,
    input logic [7:0] s3,
    input logic [7:0] held
  );
    return (s2 & s3) | (held & (s2 | s3));
  endfunction : settle

  // digital bits of a port, analog ones excluded
  function automatic logic [7:0] digital_bits(
    input logic [7:0] impl,
    input gpb_cfg_t   c
  );
    return impl & ~c.analog_digital_select;
  endfunction : digital_bits

  // digital bits whose direction is output
  function automatic logic [7:0] output_bits(
    input logic [7:0] impl,
    input gpb_cfg_t   c
  );
    return digital_bits(impl, c) & ~c.direction;
  endfunction : output_bits

  // pull-up only on digital inputs; an output would fight it
  function automatic logic [7:0] pullup_bits(
    input logic [7:0] impl,
    input gpb_cfg_t   c
  );
    return c.pullup_select & digital_bits(impl, c) & c.direction;
  endfunction : pullup_bits

  // read value: latch for outputs, filtered pin for digital inputs
  function automatic logic [7:0] read_bits(
    input logic [7:0] impl,
    input gpb_cfg_t   c,
    input logic [7:0] level
  );
    return (output_bits(impl, c) & c.data) |
           (digital_bits(impl, c) & c.direction & level);
  endfunction : read_bits

  gpb_state_t st_reg;
  gpb_state_t st_next;
  gpb_state_t st_rst;

  // reset image: all input, analog selected where the bit has an analog path; analog_en and the other outputs load zero
  always_comb begin
    st_rst = '0;
    for (int p = 0; p < `GPB_NPORT; p++) begin
      st_rst.cfg[p].data                  = `GPB_ZERO8;
      st_rst.cfg[p].direction             = `GPB_ONES8;
      st_rst.cfg[p].pullup_select         = `GPB_ZERO8;
      st_rst.cfg[p].output_type           = `GPB_ZERO8;
      st_rst.cfg[p].analog_digital_select =
        mask_of(PINS, p, GPB_K_ANA);
    end
  end

  always_comb begin
    logic [7:0] impl;
    logic [7:0] odm;
    logic [7:0] anam;
    logic [7:0] is_out;
    logic [7:0] is_dig;
    logic [7:0] od;
    gpb_cfg_t   c;
    impl    = `GPB_ZERO8;
    odm     = `GPB_ZERO8;
    anam    = `GPB_ZERO8;
    is_out  = `GPB_ZERO8;
    is_dig  = `GPB_ZERO8;
    od      = `GPB_ZERO8;
    c       = '0;
    st_next = st_reg;
    for (int p = 0; p < `GPB_NPORT; p++) begin
      impl = mask_of(PINS, p, GPB_K_IMPL);
      odm  = mask_of(PINS, p, GPB_K_OD);
      anam = mask_of(PINS, p, GPB_K_ANA);
      c    = st_reg.cfg[p];
      if (WR[p].data) begin
        c.data = merge(c.data, WR_DATA, impl);
      end
      if (WR[p].direction) begin
        c.direction = merge(c.direction, WR_DATA, impl);
      end
      if (WR[p].pullup_select) begin
        c.pullup_select = merge(c.pullup_select, WR_DATA, impl);
      end
      if (WR[p].output_type) begin
        c.output_type = merge(c.output_type, WR_DATA, odm);
      end
      if (WR[p].analog_digital_select) begin
        c.analog_digital_select =
          merge(c.analog_digital_select, WR_DATA, anam);
      end
      st_next.cfg[p] = c;

      // pin sampling: three stages, level moves when stages 2 and 3 agree
      st_next.sync1[p] = PIN_IN[p];
      st_next.sync2[p] = st_reg.sync1[p];
      st_next.sync3[p] = st_reg.sync2[p];
      st_next.level[p] =
        settle(st_reg.sync2[p], st_reg.sync3[p],
               st_reg.level[p]);

      // outputs are registered from the updated configuration on the same edge as it
      is_dig = digital_bits(impl, c);
      is_out = output_bits(impl, c);
      od     = c.output_type & odm;
      // open-drain drives only low and floats for a one
      st_next.pin_out[p] = c.data & ~od & is_out;
      st_next.pin_oe[p]  = is_out & ~(od & c.data);
      // analog or output bits never keep the pull-up
      st_next.pullup_en[p] =
        pullup_bits(impl, c);
      st_next.analog_en[p] = impl & c.analog_digital_select;
      // analog bits read as zero; unimplemented bits read as zero
      st_next.rdata[p] =
        read_bits(impl, c, st_reg.level[p]);
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      st_reg <= st_rst;
    end else begin
      st_reg <= st_next;
    end
  end

  assign PIN_OUT   = st_reg.pin_out;
  assign PIN_OE    = st_reg.pin_oe;
  assign PULLUP_EN = st_reg.pullup_en;
  assign ANALOG_EN = st_reg.analog_en;
  assign RDATA     = st_reg.rdata;
  assign CFG       = st_reg.cfg;

endmodule : gpb_port_bank

// *** testbench/gpb_checker.sv ***
// assertions on the port bank outputs
module gpb_checker
  import gpb_pkg::*;
#(
  parameter int PINS = 20
) (
  // clock and reset
  input wire logic           REF_CLK,
  input wire logic           RST,
  // watched ports
  input wire gpb_wr_t [2:0]  WR,
  input wire logic [7:0]     WR_DATA,
  input wire gpb_vec_t       PIN_OUT,
  input wire gpb_vec_t       PIN_OE,
  input wire gpb_vec_t       PULLUP_EN,
  input wire gpb_vec_t       RDATA,
  input wire gpb_cfg_t [2:0] CFG
);
  localparam logic [7:0] ANA0 = PINS == 8 ? 8'h1A : PINS == 10 ? 8'h1E : 8'hFE;
  localparam logic [7:0] ANA2 = PINS == 20 ? 8'h0F : 8'h00;
  // only the 16 and 20 pin packages are fully checked below
  wire logic [7:0] out0 = ~CFG[0].direction & ~CFG[0].analog_digital_select;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  reset_config_a: assert property (disable iff (1'b0) RST |=>
    CFG[0].direction == 8'hFF && CFG[0].analog_digital_select == ANA0 &&
    CFG[1].analog_digital_select == ANA2 && CFG[2].direction == 8'hFF)
    else $error("config not at reset values");
  p0_dir_take_a: assert property (WR[0].direction |=>
    CFG[0].direction == $past(WR_DATA)) else $error("p0 direction lost");
  p4_dir_take_a: assert property (WR[2].direction |=>
    CFG[2].direction == ($past(WR_DATA) | 8'hFC)) else $error("p4 direction");
  p0_bit2_pp_a: assert property (CFG[0].output_type[2] == 1'b0)
    else $error("p0 bit2 open drain");
  od_bits_a: assert property ((CFG[1].output_type & 8'hFB) == 8'h00 &&
    (CFG[2].output_type & 8'hFD) == 8'h00) else $error("bad open drain bit");
  latch_drive_a: assert property (PIN_OUT[0] ==
    (CFG[0].data & out0 & ~CFG[0].output_type)) else $error("p0 drive value");
  drive_enable_a: assert property (PIN_OE[0] ==
    (out0 & ~(CFG[0].output_type & CFG[0].data))) else $error("p0 enable");
  pullup_gate_a: assert property (PULLUP_EN[0] == (CFG[0].pullup_select &
    CFG[0].direction & ~CFG[0].analog_digital_select)) else $error("p0 pullup");
  read_latch_a: assert property (((RDATA[0] ^ CFG[0].data) & out0) == 8'h00
    && (RDATA[0] & CFG[0].analog_digital_select) == 8'h00)
    else $error("p0 read value");
endmodule : gpb_checker

bind gpb_port_bank gpb_checker #(.PINS(PINS)) u_chk (.REF_CLK(REF_CLK),
  .RST(RST), .WR(WR), .WR_DATA(WR_DATA), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE),
  .PULLUP_EN(PULLUP_EN), .RDATA(RDATA), .CFG(CFG));

// *** testbench/gpb_pin_model.sv ***
// board side of the pins: drivers, pull-ups, floating lines
module gpb_pin_model
  import gpb_pkg::*;
(
  // clock
  input wire logic     clk,
  // from the bank and the bench
  input wire gpb_vec_t pin_out,
  input wire gpb_vec_t pin_oe,
  input wire gpb_vec_t pullup_en,
  input wire gpb_vec_t ext_val,
  input wire gpb_vec_t ext_en,
  // resolved levels
  output gpb_vec_t     pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // a floating line toggles so it never passes for a stable level
  logic flt_reg = 1'b0;
  always_ff @(posedge clk) flt_reg <= ~flt_reg;
  always_comb pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) |
    (~pin_oe & ~ext_en & (pullup_en | {24{flt_reg}}));
endmodule : gpb_pin_model

// *** testbench/tb.sv ***
// bench for the port bank
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import gpb_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  gpb_wr_t [2:0] wr = '0;
  logic [7:0] wd = 8'h00;
  gpb_vec_t pin_in, p_out, p_oe, pu, an, rd;
  gpb_vec_t xv = '0;
  gpb_vec_t xe = '0;
  gpb_cfg_t [2:0] cfg;
  int n_fail = 0;
  int checks = 0;
  gpb_port_bank #(.PINS(20)) dut (.REF_CLK(clk), .RST(rst), .WR(wr),
    .WR_DATA(wd), .PIN_IN(pin_in), .PIN_OUT(p_out), .PIN_OE(p_oe),
    .PULLUP_EN(pu), .ANALOG_EN(an), .RDATA(rd), .CFG(cfg));
  gpb_pin_model pins (.clk(clk), .pin_out(p_out), .pin_oe(p_oe),
    .pullup_en(pu), .ext_val(xv), .ext_en(xe), .pin_in(pin_in));
  initial forever #10 clk = ~clk;
  // k: 0 data, 1 direction, 2 pull-up, 3 output type, 4 analog
  task automatic wr_reg(int p, int k, logic [7:0] d);
    @(posedge clk);
    wr[p] <= gpb_wr_t'(5'h10 >> k);
    wd <= d;
    @(posedge clk);
    wr[p] <= '0;
    #1;
  endtask : wr_reg
  task automatic chk(string s, logic [7:0] e, logic [7:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task automatic finish_test;
    if (n_fail == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test
  initial begin
    #20000;
    n_fail++;
    finish_test();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("p0 ana", 8'hFE, cfg[0].analog_digital_select);
    chk("p2 ana", 8'h0F, cfg[1].analog_digital_select);
    chk("p4 dir", 8'hFF, cfg[2].direction);
    wr_reg(0, 4, 8'h00);
    wr_reg(0, 0, 8'hA5);
    wr_reg(0, 1, 8'h00);
    chk("p0 oe", 8'hFF, p_oe[0]);
    chk("p0 out", 8'hA5, p_out[0]);
    chk("p0 rd", 8'hA5, rd[0]);
    wr_reg(0, 3, 8'hFF);
    chk("p0 otype", 8'hFB, cfg[0].output_type);
    chk("p0 od oe", 8'h5E, p_oe[0]);
    chk("p0 od out", 8'h04, p_out[0]);
    wr_reg(1, 3, 8'hFF);
    chk("p2 otype", 8'h04, cfg[1].output_type);
    wr_reg(2, 3, 8'hFF);
    chk("p4 otype", 8'h02, cfg[2].output_type);
    wr_reg(1, 4, 8'h00);
    wr_reg(1, 0, 8'h0F);
    wr_reg(1, 1, 8'h0C);
    chk("p2 dir", 8'hFC, cfg[1].direction);
    chk("p2 oe", 8'h03, p_oe[1]);
    chk("p2 out", 8'h03, p_out[1]);
    wr_reg(1, 2, 8'hFF);
    chk("p2 pu", 8'h0C, pu[1]);
    wr_reg(2, 2, 8'hFF);
    chk("p4 pu", 8'h03, pu[2]);
    @(posedge clk) xe[2] <= 8'h01;
    repeat (6) @(posedge clk);
    #1;
    chk("p4 rd", 8'h02, rd[2]);
    wr_reg(2, 1, 8'h00);
    chk("p4 dir", 8'hFC, cfg[2].direction);
    chk("p4 pu off", 8'h00, pu[2]);
    wr_reg(0, 1, 8'hFF);
    wr_reg(0, 4, 8'hF0);
    wr_reg(0, 2, 8'hFF);
    chk("p0 pu", 8'h0F, pu[0]);
    chk("p0 an", 8'hF0, an[0]);
    @(posedge clk) rst <= 1'b1;
    @(posedge clk) rst <= 1'b0;
    #1;
    chk("p0 reana", 8'hFE, cfg[0].analog_digital_select);
    chk("p0 oe rst", 8'h00, p_oe[0]);
    finish_test();
  end
endmodule : tb
